// ===== core/gdp_ports.sv
// general-purpose port block: direction registers, key, irq, output-only and multi ports
`timescale 1ns/1ns
module gdp_ports (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [15:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire gdp_pkg::gdp_acc_e ACC_MODE,
    input wire logic [2:0] BIT_SEL,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    input wire logic EXP_MODE,
    input wire logic WAIT_EN,
    output logic [7:0] PORT6_DIR,
    input wire logic [7:0] KEY_PIN_IN,
    output logic [7:0] KEY_PIN_OUT,
    output logic [7:0] KEY_PIN_OE_N,
    output logic [7:0] KEY_PULLUP_EN,
    output logic [7:0] KEY_RETURN_INPUTS,
    input wire logic IRQ_PIN_IN,
    output logic IRQ_PIN_OUT,
    output logic IRQ_PIN_OE_N,
    output logic IRQ_PULLUP_EN,
    output logic IRQ_REQUEST_IN,
    output logic RESET_LOW_OUTPUT_PIN,
    input wire logic [5:0] MULTI_PIN_IN,
    output logic [5:0] MULTI_PIN_OUT,
    output logic [5:0] MULTI_PIN_OE_N,
    output logic [5:0] MULTI_PULLUP_EN,
    input wire logic [5:0] MULTI_ALT_OUT_EN,
    input wire logic [5:0] MULTI_ALT_OUT,
    output logic [5:0] MULTI_ALT_IN
);
    import gdp_pkg::*;

    // merge a byte or single-bit write into a register, keeping absent bits fixed
    function automatic logic [7:0] gdp_merge(input logic [7:0] cur, input logic [7:0] mask,
                                             input logic [7:0] fill, input gdp_acc_e mode,
                                             input logic [2:0] sel, input logic [7:0] wd);
        logic [7:0] nv;
        nv = cur;
        if (mode == GDP_ACC_BIT) begin
            nv[sel] = wd[0];
        end else begin
            nv = wd;
        end
        gdp_merge = (nv & mask) | (fill & ~mask);
    endfunction : gdp_merge

    // register state
    logic [7:0] dir_p0, dir_p1, dir_p3, dir_p4, dir_p5, dir_p6; // other ports' direction
    logic [7:0] dir_key; // key port direction
    logic [7:0] dir_irq; // irq port direction
    logic [7:0] dir_multi; // multi port direction
    logic [7:0] lat_key, lat_irq, lat_out, lat_multi; // output latches
    logic [7:0] pu_key, pu_irq, pu_multi; // pull-up selects
    // pin synchronisers, stage one read only by stage two
    logic [7:0] key_s1, key_s2;
    logic irq_s1, irq_s2;
    logic [5:0] multi_s1, multi_s2;

    // write strobe for one address
    function automatic logic gdp_hit(input logic [15:0] a, input logic [15:0] r, input logic we);
        gdp_hit = we && (a == r);
    endfunction : gdp_hit

    // direction registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dir_p0 <= GDP_DIR_RESET;
            dir_p1 <= GDP_DIR_RESET;
            dir_p3 <= GDP_DIR_RESET;
            dir_p4 <= GDP_DIR_RESET;
            dir_p5 <= GDP_DIR_RESET;
            dir_p6 <= GDP_DIR_RESET;
            dir_key <= GDP_DIR_RESET;
            dir_irq <= GDP_DIR_RESET;
            dir_multi <= GDP_DIR_RESET;
        end else begin
            // bit or byte writes, fill for absent bits
            if (gdp_hit(ADDR, GDP_ADDR_DIR0, WR_EN)) begin
                dir_p0 <= gdp_merge(dir_p0, GDP_MASK_P0, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_DIR1, WR_EN)) begin
                dir_p1 <= gdp_merge(dir_p1, GDP_MASK_FULL, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_DIR3, WR_EN)) begin
                dir_p3 <= gdp_merge(dir_p3, GDP_MASK_P3, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_DIR4, WR_EN)) begin
                dir_p4 <= gdp_merge(dir_p4, GDP_MASK_FULL, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_DIR5, WR_EN)) begin
                dir_p5 <= gdp_merge(dir_p5, GDP_MASK_FULL, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_DIR6, WR_EN)) begin
                dir_p6 <= gdp_merge(dir_p6, GDP_MASK_FULL, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_DIRK, WR_EN)) begin
                dir_key <= gdp_merge(dir_key, GDP_MASK_FULL, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            // only bit 0 exists on the irq port
            if (gdp_hit(ADDR, GDP_ADDR_DIRI, WR_EN)) begin
                dir_irq <= gdp_merge(dir_irq, GDP_MASK_IRQ, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_DIRM, WR_EN)) begin
                dir_multi <= gdp_merge(dir_multi, GDP_MASK_MULTI, GDP_DIR_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
        end
    end

    // output latches; the output-only latch also resets, so its pin drops low
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lat_key <= GDP_LATCH_RESET;
            lat_irq <= GDP_LATCH_RESET;
            lat_multi <= GDP_LATCH_RESET;
            lat_out <= GDP_LATCH_RESET;
        end else begin
            if (gdp_hit(ADDR, GDP_ADDR_KDAT, WR_EN)) begin
                lat_key <= gdp_merge(lat_key, GDP_MASK_FULL, GDP_LATCH_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_IDAT, WR_EN)) begin
                lat_irq <= gdp_merge(lat_irq, GDP_MASK_IRQ, GDP_LATCH_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_ODAT, WR_EN)) begin
                lat_out <= gdp_merge(lat_out, GDP_MASK_OUT, GDP_LATCH_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_MDAT, WR_EN)) begin
                lat_multi <= gdp_merge(lat_multi, GDP_MASK_MULTI, GDP_LATCH_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
        end
    end

    // pull-up option registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pu_key <= GDP_PU_RESET;
            pu_irq <= GDP_PU_RESET;
            pu_multi <= GDP_PU_RESET;
        end else begin
            if (gdp_hit(ADDR, GDP_ADDR_KPU, WR_EN)) begin
                pu_key <= gdp_merge(pu_key, GDP_MASK_FULL, GDP_PU_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_IPU, WR_EN)) begin
                pu_irq <= gdp_merge(pu_irq, GDP_MASK_IRQ, GDP_PU_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
            if (gdp_hit(ADDR, GDP_ADDR_MPU, WR_EN)) begin
                pu_multi <= gdp_merge(pu_multi, GDP_MASK_MULTI, GDP_PU_RESET, ACC_MODE, BIT_SEL, WDATA);
            end
        end
    end

    // two-flop pin synchronisers; pins are asynchronous to CLK
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            key_s1 <= 8'h00;
            key_s2 <= 8'h00;
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
            multi_s1 <= 6'h00;
            multi_s2 <= 6'h00;
        end else begin
            key_s1 <= KEY_PIN_IN;
            key_s2 <= key_s1;
            irq_s1 <= IRQ_PIN_IN;
            irq_s2 <= irq_s1;
            multi_s1 <= MULTI_PIN_IN;
            multi_s2 <= multi_s1;
        end
    end

    // pin drive; oe_n low drives the pin, so direction bit maps straight
    // direction 0 drives
    assign KEY_PIN_OE_N = dir_key;
    assign KEY_PIN_OUT = lat_key;
    assign IRQ_PIN_OE_N = dir_irq[0];
    assign IRQ_PIN_OUT = lat_irq[0];
    assign RESET_LOW_OUTPUT_PIN = lat_out[0];

    // multi port: alternate output overrides the latch when its owner enables it and the pin is in output mode
    logic [5:0] multi_alt_drive; // alternate output active and pin in output mode
    assign multi_alt_drive = MULTI_ALT_OUT_EN & ~dir_multi[5:0];
    assign MULTI_PIN_OE_N = dir_multi[5:0];
    assign MULTI_PIN_OUT = (multi_alt_drive & MULTI_ALT_OUT) | (~multi_alt_drive & lat_multi[5:0]);
    assign MULTI_ALT_IN = multi_s2;

    // pull-ups only in input mode and never under alternate output
    // key pull-up
    assign KEY_PULLUP_EN = pu_key & dir_key;
    assign IRQ_PULLUP_EN = pu_irq[0] & dir_irq[0];
    assign MULTI_PULLUP_EN = pu_multi[5:0] & dir_multi[5:0] & ~MULTI_ALT_OUT_EN;

    // alternate inputs are the synchronised pin levels, valid when input mode
    // key return inputs
    assign KEY_RETURN_INPUTS = key_s2 & dir_key;
    assign IRQ_REQUEST_IN = irq_s2 & dir_irq[0];

    // wait pin is plain I/O unless expansion wait is on; expansion logic
    // owns the pin by mode register, so the wait bit of the direction output is forced to one (input)
    assign PORT6_DIR = (EXP_MODE && WAIT_EN) ? (dir_p6 | (8'h01 << GDP_WAIT_BIT)) : dir_p6;

    // pin level in input mode, latch in output mode
    function automatic logic [7:0] gdp_readback(input logic [7:0] dir, input logic [7:0] lat,
                                                input logic [7:0] pin);
        gdp_readback = (dir & pin) | (~dir & lat);
    endfunction : gdp_readback

    // registered read data; unmapped reads return zero
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (RD_EN) begin
            case (ADDR)
                GDP_ADDR_DIR0: RDATA <= dir_p0;
                GDP_ADDR_DIR1: RDATA <= dir_p1;
                GDP_ADDR_DIR3: RDATA <= dir_p3;
                GDP_ADDR_DIR4: RDATA <= dir_p4;
                GDP_ADDR_DIR5: RDATA <= dir_p5;
                GDP_ADDR_DIR6: RDATA <= dir_p6;
                GDP_ADDR_DIRK: RDATA <= dir_key;
                GDP_ADDR_DIRI: RDATA <= dir_irq;
                GDP_ADDR_DIRM: RDATA <= dir_multi;
                GDP_ADDR_KDAT: RDATA <= gdp_readback(dir_key, lat_key, key_s2);
                GDP_ADDR_IDAT: RDATA <= gdp_readback(dir_irq, lat_irq, {7'h00, irq_s2}) & GDP_MASK_IRQ;
                GDP_ADDR_ODAT: RDATA <= lat_out;
                GDP_ADDR_MDAT: RDATA <= gdp_readback(dir_multi, lat_multi, {2'h0, multi_s2}) & GDP_MASK_MULTI;
                GDP_ADDR_KPU: RDATA <= pu_key;
                GDP_ADDR_IPU: RDATA <= pu_irq;
                GDP_ADDR_MPU: RDATA <= pu_multi;
                default: RDATA <= 8'h00;
            endcase
        end
    end

    // checks on pin and register behaviour; pull-ups, drive and reset are watched every cycle

    // named steps: a request on one register, seen on the outputs one cycle later
    sequence s_key_byte_write;
        WR_EN && ADDR == GDP_ADDR_DIRK && ACC_MODE == GDP_ACC_BYTE;
    endsequence
    sequence s_key_bit_write;
        WR_EN && ADDR == GDP_ADDR_DIRK && ACC_MODE == GDP_ACC_BIT;
    endsequence
    sequence s_out_byte_write;
        WR_EN && ADDR == GDP_ADDR_ODAT && ACC_MODE == GDP_ACC_BYTE;
    endsequence
    sequence s_key_latch_read;
        RD_EN && ADDR == GDP_ADDR_KDAT && dir_key == 8'h00;
    endsequence

    // reset behaviour, looked at on the edge after reset is seen
    // key, irq and multi directions all ones
    a_dir_reset: assert property (@(posedge CLK)
        !RST_N |=> (dir_key == GDP_DIR_RESET && dir_multi == GDP_DIR_RESET && dir_irq == GDP_DIR_RESET))
        else $error("direction not all ones");
    a_outpin_low: assert property (@(posedge CLK)
        !RST_N |=> !RESET_LOW_OUTPUT_PIN) else $error("output pin not low after reset");
    a_latch_clear: assert property (@(posedge CLK)
        !RST_N |=> (KEY_PIN_OUT == 8'h00 && !IRQ_PIN_OUT && MULTI_PIN_OUT == 6'h00))
        else $error("latch not cleared");

    // register writes and reads
    // byte write lands
    a_key_write: assert property (@(posedge CLK) disable iff (!RST_N)
        s_key_byte_write |=> KEY_PIN_OE_N == $past(WDATA)) else $error("key direction byte write lost");
    a_key_bit_write: assert property (@(posedge CLK) disable iff (!RST_N)
        s_key_bit_write |=> ((KEY_PIN_OE_N ^ $past(KEY_PIN_OE_N)) & ~(8'h01 << $past(BIT_SEL))) == 8'h00)
        else $error("key direction bit write touched other bits");
    a_outpin_write: assert property (@(posedge CLK) disable iff (!RST_N)
        s_out_byte_write |=> RESET_LOW_OUTPUT_PIN == $past(WDATA[0])) else $error("output pin not from latch");
    a_irq_absent: assert property (@(posedge CLK) disable iff (!RST_N)
        dir_irq[7:1] == 7'h7F) else $error("absent irq direction bits not one");
    a_multi_absent: assert property (@(posedge CLK) disable iff (!RST_N)
        dir_multi[7:6] == 2'h3) else $error("absent multi direction bits not one");
    a_read_latch: assert property (@(posedge CLK) disable iff (!RST_N)
        s_key_latch_read |=> RDATA == $past(lat_key)) else $error("output-mode read not latch");

    // pin side; these hold whatever software writes, so they run every cycle
    // multi pull-up off when driven
    a_pullup_output: assert property (@(posedge CLK) disable iff (!RST_N)
        (MULTI_PULLUP_EN & ~MULTI_PIN_OE_N) == 6'h00) else $error("pull-up on driven pin");
    a_pull_driven: assert property (@(posedge CLK) disable iff (!RST_N)
        (KEY_PULLUP_EN & ~KEY_PIN_OE_N) == 8'h00 && !(IRQ_PULLUP_EN && !IRQ_PIN_OE_N))
        else $error("pull-up on driven key or irq pin");
    a_key_pullup: assert property (@(posedge CLK) disable iff (!RST_N)
        (KEY_PULLUP_EN & ~pu_key) == 8'h00) else $error("key pull-up wrong");
    a_alt_out: assert property (@(posedge CLK) disable iff (!RST_N)
        ((MULTI_PIN_OUT ^ MULTI_ALT_OUT) & MULTI_ALT_OUT_EN & ~MULTI_PIN_OE_N) == 6'h00)
        else $error("alternate output not on pin");
    a_key_return: assert property (@(posedge CLK) disable iff (!RST_N)
        (KEY_RETURN_INPUTS & ~KEY_PIN_OE_N) == 8'h00) else $error("key return on driven pin");
    a_wait_input: assert property (@(posedge CLK) disable iff (!RST_N)
        (EXP_MODE && WAIT_EN) |-> PORT6_DIR[GDP_WAIT_BIT]) else $error("wait pin not input");
    a_wait_free: assert property (@(posedge CLK) disable iff (!RST_N)
        !(EXP_MODE && WAIT_EN) |-> PORT6_DIR == dir_p6) else $error("wait pin direction overridden");
endmodule : gdp_ports

// ===== core/gdp_pkg.sv
// constants shared by the general-purpose port block
package gdp_pkg;
    // register addresses
    localparam logic [15:0] GDP_ADDR_DIR0 = 16'hFF20;
    localparam logic [15:0] GDP_ADDR_DIR1 = 16'hFF21;
    localparam logic [15:0] GDP_ADDR_DIR3 = 16'hFF23;
    localparam logic [15:0] GDP_ADDR_DIR4 = 16'hFF24;
    localparam logic [15:0] GDP_ADDR_DIR5 = 16'hFF25;
    localparam logic [15:0] GDP_ADDR_DIR6 = 16'hFF26;
    localparam logic [15:0] GDP_ADDR_DIRK = 16'hFF27;
    localparam logic [15:0] GDP_ADDR_DIRI = 16'hFF2C;
    localparam logic [15:0] GDP_ADDR_DIRM = 16'hFF2E;
    localparam logic [15:0] GDP_ADDR_KDAT = 16'hFF07;
    localparam logic [15:0] GDP_ADDR_IDAT = 16'hFF0C;
    localparam logic [15:0] GDP_ADDR_ODAT = 16'hFF0D;
    localparam logic [15:0] GDP_ADDR_MDAT = 16'hFF0E;
    localparam logic [15:0] GDP_ADDR_KPU = 16'hFF37;
    localparam logic [15:0] GDP_ADDR_IPU = 16'hFF3C;
    localparam logic [15:0] GDP_ADDR_MPU = 16'hFF3E;
    // reset values
    localparam logic [7:0] GDP_DIR_RESET = 8'hFF;
    localparam logic [7:0] GDP_LATCH_RESET = 8'h00;
    localparam logic [7:0] GDP_PU_RESET = 8'h00;
    // implemented bit masks, 1 = a pin exists
    localparam logic [7:0] GDP_MASK_FULL = 8'hFF;
    localparam logic [7:0] GDP_MASK_IRQ = 8'h01;
    localparam logic [7:0] GDP_MASK_OUT = 8'h01;
    localparam logic [7:0] GDP_MASK_MULTI = 8'h3F;
    localparam logic [7:0] GDP_MASK_P0 = 8'h7F;
    localparam logic [7:0] GDP_MASK_P3 = 8'h0F;
    // wait-shared pin position in the port 6 direction register
    localparam int GDP_WAIT_BIT = 6;
    // access width selector
    typedef enum logic [0:0] {GDP_ACC_BYTE = 1'b0, GDP_ACC_BIT = 1'b1} gdp_acc_e;
endpackage : gdp_pkg

// ===== testbench/gdp_pin_model.sv
// external circuitry on a group of port pins, resolving each wire level
`timescale 1ns/1ns
module gdp_pin_model #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe_n,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] pin
);
    // last resolved level, used to make a floating wire wander; unknown counts as low
    logic [W-1:0] last;
    // device drive wins, then outside drive, then pull-up, else a toggling float
    // a float never repeats the old level, so a stale read cannot pass by luck
    assign pin = (~oe_n & out) | (oe_n & ext_en & ext_val) | (oe_n & ~ext_en & (pu | ~last));
    // remember the level for the float pattern
    // an unknown level before reset must not lock the float at unknown for good
    always_ff @(posedge clk) begin
        for (int i = 0; i < W; i++) begin
            last[i] <= (pin[i] === 1'b1);
        end
    end
endmodule : gdp_pin_model

// ===== testbench/gdp_ports_tb.sv
// self-checking bench for the general-purpose port block
`timescale 1ns/1ns
module gdp_ports_tb;
    import gdp_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, exp_mode = 1'b0, wait_en = 1'b0;
    logic [15:0] addr = 16'h0000;
    gdp_acc_e acc_mode = GDP_ACC_BYTE;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, p6dir, kin, kout, koe, kpu, kret, kxe = 8'h00, kxv = 8'h00, d;
    logic iin, iout, ioe, ipu, ireq, rlo, ixe = 1'b0, ixv = 1'b0;
    logic [5:0] min, mout, moe, mpu, maen = 6'h00, malt = 6'h00, mai, mxe = 6'h00, mxv = 6'h00;
    int err_count = 0, total_checks = 0;
    // direction register map and their implemented bits
    logic [15:0] da [9] = '{GDP_ADDR_DIR0, GDP_ADDR_DIR1, GDP_ADDR_DIR3, GDP_ADDR_DIR4, GDP_ADDR_DIR5,
        GDP_ADDR_DIR6, GDP_ADDR_DIRK, GDP_ADDR_DIRI, GDP_ADDR_DIRM};
    logic [7:0] dm [9] = '{8'h7F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h3F};
    // 25 MHz clock
    always #20 clk = ~clk;
    gdp_ports u_dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
        .ACC_MODE(acc_mode), .BIT_SEL(bit_sel), .WDATA(wdata), .RDATA(rdata), .EXP_MODE(exp_mode),
        .WAIT_EN(wait_en), .PORT6_DIR(p6dir), .KEY_PIN_IN(kin), .KEY_PIN_OUT(kout), .KEY_PIN_OE_N(koe),
        .KEY_PULLUP_EN(kpu), .KEY_RETURN_INPUTS(kret), .IRQ_PIN_IN(iin), .IRQ_PIN_OUT(iout),
        .IRQ_PIN_OE_N(ioe), .IRQ_PULLUP_EN(ipu), .IRQ_REQUEST_IN(ireq), .RESET_LOW_OUTPUT_PIN(rlo),
        .MULTI_PIN_IN(min), .MULTI_PIN_OUT(mout), .MULTI_PIN_OE_N(moe), .MULTI_PULLUP_EN(mpu),
        .MULTI_ALT_OUT_EN(maen), .MULTI_ALT_OUT(malt), .MULTI_ALT_IN(mai));
    // far-side circuitry for the three bidirectional groups
    gdp_pin_model #(.W(8)) u_key (.clk(clk), .out(kout), .oe_n(koe), .pu(kpu), .ext_en(kxe), .ext_val(kxv), .pin(kin));
    gdp_pin_model #(.W(1)) u_irq (.clk(clk), .out(iout), .oe_n(ioe), .pu(ipu), .ext_en(ixe), .ext_val(ixv), .pin(iin));
    gdp_pin_model #(.W(6)) u_mul (.clk(clk), .out(mout), .oe_n(moe), .pu(mpu), .ext_en(mxe), .ext_val(mxv), .pin(min));
    // compare and count
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one write cycle, byte or single bit; strobe drops one edge later
    task automatic wr(input logic [15:0] a, input logic [7:0] v, input gdp_acc_e m = GDP_ACC_BYTE,
        input logic [2:0] b = 3'h0);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        acc_mode <= m;
        bit_sel <= b;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(negedge clk);
    endtask : wr
    // one read cycle, data sampled once it has settled
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask : rd
    // verdict and end of run
    task automatic finish_test();
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // watchdog, far beyond the hundred-odd cycles the tests need
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        // all pins released, irq, multi and key bits 7:1 pull-ups off, output-only pin low after reset
        chk("reset key oe", koe, 8'hFF);
        chk("reset irq oe", {7'h7F, ioe}, 8'hFF);
        chk("reset multi oe", {2'b11, moe}, 8'hFF);
        chk("reset low pin", {7'h00, rlo}, 8'h00);
        chk("reset pullups", {kpu[7:1], ipu} | {mpu, 2'b00}, 8'h00);
        for (int i = 0; i < 9; i++) begin
            rd(da[i], d);
            chk("dir reset", d, 8'hFF);
            wr(da[i], 8'h00);
            rd(da[i], d);
            chk("dir absent bits", d, ~dm[i]);
            wr(da[i], 8'hFF);
        end
        // single-bit write clears one direction bit only
        wr(GDP_ADDR_DIRK, 8'h00, GDP_ACC_BIT, 3'h3);
        chk("key oe bit", koe, 8'hF7);
        // key port in output mode drives its latch
        wr(GDP_ADDR_KDAT, 8'hA5);
        wr(GDP_ADDR_DIRK, 8'h00);
        chk("key out", kout, 8'hA5);
        chk("key oe", koe, 8'h00);
        rd(GDP_ADDR_KDAT, d);
        chk("key read latch", d, 8'hA5);
        // input mode reads the pin; key return follows
        wr(GDP_ADDR_DIRK, 8'hFF);
        kxe <= 8'hFF;
        kxv <= 8'h3C;
        repeat (3) @(posedge clk);
        rd(GDP_ADDR_KDAT, d);
        chk("key read pin", d, 8'h3C);
        chk("key return", kret, 8'h3C);
        // pull-up only on input bits
        wr(GDP_ADDR_DIRK, 8'h0F);
        wr(GDP_ADDR_KPU, 8'hFF);
        chk("key pullup", kpu, 8'h0F);
        chk("key return gated", kret, 8'h0C);
        // irq pin: input with pull-up, then request path
        wr(GDP_ADDR_IPU, 8'h01);
        chk("irq pullup", {7'h00, ipu}, 8'h01);
        ixe <= 1'b1;
        ixv <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("irq request", {7'h00, ireq}, 8'h00);
        ixv <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("irq request high", {7'h00, ireq}, 8'h01);
        // irq pin released by outside before the device drives it
        ixe <= 1'b0;
        wr(GDP_ADDR_IDAT, 8'h01);
        wr(GDP_ADDR_DIRI, 8'h00);
        chk("irq drive", {6'h00, ioe, iout}, 8'h01);
        chk("irq pullup out", {7'h00, ipu}, 8'h00);
        // multi port: alternate output wins when enabled in output mode
        // alternate output uses direction 0, latch 0
        wr(GDP_ADDR_MPU, 8'h3F);
        wr(GDP_ADDR_DIRM, 8'h00);
        @(posedge clk);
        maen <= 6'h01;
        malt <= 6'h01;
        @(negedge clk);
        chk("multi alt out", {2'b00, mout}, 8'h01);
        chk("multi pullup out", {2'b00, mpu}, 8'h00);
        wr(GDP_ADDR_DIRM, 8'h3F);
        @(posedge clk);
        maen <= 6'h00;
        mxe <= 6'h3F;
        mxv <= 6'h2A;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("multi alt in", {2'b00, mai}, 8'h2A);
        chk("multi pullup in", {2'b00, mpu}, 8'h3F);
        rd(GDP_ADDR_MDAT, d);
        chk("multi read pin", d, 8'h2A);
        // wait-shared pin forced to input only while wait is in use
        wr(GDP_ADDR_DIR6, 8'h00);
        @(posedge clk);
        exp_mode <= 1'b1;
        wait_en <= 1'b1;
        @(negedge clk);
        chk("wait pin used", p6dir, 8'h40);
        @(posedge clk);
        wait_en <= 1'b0;
        @(negedge clk);
        chk("wait pin free", p6dir, 8'h00);
        rd(16'hFF10, d);
        chk("unmapped read", d, 8'h00);
        // output-only pin high, then a second reset pulls it low
        wr(GDP_ADDR_ODAT, 8'h01);
        chk("low pin set", {7'h00, rlo}, 8'h01);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("low pin reset", {7'h00, rlo}, 8'h00);
        chk("latch reset", kout, 8'h00);
        chk("key dir reset", koe, 8'hFF);
        @(posedge clk);
        rst_n <= 1'b1;
        finish_test();
    end
endmodule : gdp_ports_tb
